//--- dv/sensor_result_register_map_test.sv
`timescale 1ns/10ps
`default_nettype none
module sensor_result_register_map_test;
   logic clk, rst_b, regWr, regRd, moveCntFull, resultStb, intervalStb, irq;
   logic [7:0] regAddr, regWdata, regRdata, intervalNum, intervalIn;
   logic [15:0] maxNum, maxDen, angleIn;
   logic [95:0] countIn;
   logic [31:0] ltaIn;
   srrm_pkg::srrm_fe_t frontEnd0, frontEnd1;
   int errorCnt = 0;
   int numChecks = 0;
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   srrm_register_map DUT (.*);
   srrm_sense_model u_model (.*);
   // Compare and count
   task automatic check(input logic [15:0] got, exp);
      numChecks++;
      if (got !== exp) begin
         errorCnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle register write, then one idle edge
   task automatic wr(input logic [7:0] a, d);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   endtask
   // One-cycle read, data taken mid-cycle in the answer cycle
   task automatic rd(input logic [7:0] a, exp);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      check({8'h00, regRdata}, {8'h00, exp});
      @(posedge clk);
   endtask
   task automatic finalReport;
      $display("checks %0d errors %0d", numChecks, errorCnt);
      if (errorCnt == 0 && numChecks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Expected decode of a select byte
   function automatic logic [15:0] expFe(input logic [7:0] v);
      return {10'h000, v[7:4] == 4'h0, v[7:4] == 4'h9, 2'b00, v[1:0]};
   endfunction
   initial begin
      logic [15:0] e;
      logic [7:0] sel[5] = '{8'h01, 8'h02, 8'h03, 8'h90, 8'h93};
      {rst_b, regWr, regRd, regAddr, regWdata} = '0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      // Reset values and interval access
      rd(srrm_pkg::ADDR_FE_SEL1, 8'h00);
      rd(srrm_pkg::ADDR_INTERVAL, 8'h00);
      wr(srrm_pkg::ADDR_INTERVAL, 8'ha5);
      check(intervalNum, 8'ha5);
      rd(srrm_pkg::ADDR_INTERVAL, 8'ha5);
      u_model.loadInt(8'h3c);
      rd(srrm_pkg::ADDR_INTERVAL, 8'h3c);
      // Angle in range, read-only, then clamped with carrying counts
      wr(srrm_pkg::ADDR_ANGLE_LO, 8'hff);
      u_model.capture(16'h0123);
      rd(srrm_pkg::ADDR_ANGLE_LO, 8'h23);
      rd(srrm_pkg::ADDR_ANGLE_HI, 8'h01);
      u_model.capture(16'h12fe);
      for (int i = 0; i < 6; i++) begin
         e = 16'h12fe + 16'(i);
         rd(8'h20 + 8'(2 * i), e[7:0]);
         rd(8'h21 + 8'(2 * i), e[15:8]);
      end
      for (int i = 0; i < 2; i++) begin
         e = 16'h13fe + 16'(i);
         rd(8'h30 + 8'(2 * i), e[7:0]);
         rd(8'h31 + 8'(2 * i), e[15:8]);
      end
      // New measurement between the two bytes of one angle
      rd(srrm_pkg::ADDR_ANGLE_LO, 8'h68);
      u_model.capture(16'h0055);
      rd(srrm_pkg::ADDR_ANGLE_HI, 8'h01);
      rd(srrm_pkg::ADDR_ANGLE_LO, 8'h68);
      rd(srrm_pkg::ADDR_ANGLE_HI, 8'h01);
      u_model.capture(16'h0055);
      rd(srrm_pkg::ADDR_ANGLE_LO, 8'h55);
      rd(srrm_pkg::ADDR_ANGLE_HI, 8'h00);
      wr(8'h7f, 8'hff);
      rd(8'h7f, 8'h00);
      // Counter full, calibration changes, interrupt masking
      rd(srrm_pkg::ADDR_RATIO_FLAGS, 8'h00);
      u_model.status(1'b1, 1'b0, 1'b0);
      repeat (2) @(posedge clk);
      rd(srrm_pkg::ADDR_RATIO_FLAGS, 8'h04);
      rd(srrm_pkg::ADDR_IRQ_STATUS, 8'h04);
      wr(srrm_pkg::ADDR_IRQ_MASK, 8'h07);
      for (int i = 0; i < 3; i++) begin
         if (i == 2) wr(srrm_pkg::ADDR_IRQ_MASK, 8'h00);
         u_model.status(1'b1, i != 1, i == 1);
         repeat (3) @(posedge clk);
         @(negedge clk);
         check(irq, i != 2);
         @(posedge clk);
         rd(srrm_pkg::ADDR_IRQ_STATUS, i == 1 ? 8'h02 : 8'h01);
         @(negedge clk);
         check(irq, 1'b0);
         @(posedge clk);
      end
      u_model.status(1'b0, 1'b0, 1'b0);
      repeat (2) @(posedge clk);
      rd(srrm_pkg::ADDR_RATIO_FLAGS, 8'h00);
      // Every mode and receive code on both channels
      for (int i = 0; i < 5; i++) begin
         wr(srrm_pkg::ADDR_FE_SEL0, sel[i]);
         wr(srrm_pkg::ADDR_FE_SEL1, sel[4-i]);
         @(negedge clk);
         check({10'h000, frontEnd0}, expFe(sel[i]));
         check({10'h000, frontEnd1}, expFe(sel[4-i]));
         @(posedge clk);
         rd(srrm_pkg::ADDR_FE_SEL0, sel[i]);
      end
      finalReport();
   end
endmodule // sensor_result_register_map_test
`default_nettype wire

//--- dv/srrm_register_map_sva.sv
`timescale 1ns/10ps
`default_nettype none
// Bus, flag and front-end checks
module srrm_chk (
   input wire logic               clk,
   input wire logic               rst_b,
   input wire logic [7:0]         regAddr,
   input wire logic [7:0]         regWdata,
   input wire logic               regWr,
   input wire logic               regRd,
   input wire logic [7:0]         regRdata,
   input wire logic               moveCntFull,
   input wire logic [15:0]        maxNum,
   input wire logic [15:0]        maxDen,
   input wire srrm_pkg::srrm_fe_t frontEnd0,
   input wire logic [7:0]         intervalNum
);
   // Access decode
   wire rdFlag = regRd && regAddr == srrm_pkg::ADDR_RATIO_FLAGS;
   wire wrSel  = regWr && regAddr == srrm_pkg::ADDR_FE_SEL0;
   wire wrInt  = regWr && regAddr == srrm_pkg::ADDR_INTERVAL;
   wire rdInt  = regRd && regAddr == srrm_pkg::ADDR_INTERVAL;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_wrInt; wrInt |=> intervalNum == $past(regWdata); endproperty
   a_wrInt: assert property (p_wrInt) else $error("interval write lost");
   property p_rdInt; rdInt |=> regRdata == $past(intervalNum); endproperty
   a_rdInt: assert property (p_rdInt) else $error("interval read wrong");
   property p_full; rdFlag |=> regRdata[7:2] == {5'h00, $past(moveCntFull, 2)}; endproperty
   a_full: assert property (p_full) else $error("full flag wrong");
   property p_num; $stable(maxNum)[*4] ##0 rdFlag |=> !regRdata[0]; endproperty
   a_num: assert property (p_num) else $error("numerator flag stuck");
   property p_den; $stable(maxDen)[*4] ##0 rdFlag |=> !regRdata[1]; endproperty
   a_den: assert property (p_den) else $error("denominator flag stuck");
   property p_mode;
      wrSel |-> ##2 frontEnd0.selfCap == ($past(regWdata[7:4], 2) == 4'h0)
         && frontEnd0.mutInd == ($past(regWdata[7:4], 2) == 4'h9);
   endproperty
   a_mode: assert property (p_mode) else $error("mode decode wrong");
   property p_tx; wrSel && regWdata[3:2] == 2'b00 |-> ##2 frontEnd0.txEn == 2'b00; endproperty
   a_tx: assert property (p_tx) else $error("transmit not off");
   property p_rx; wrSel |-> ##2 frontEnd0.rxEn == $past(regWdata[1:0], 2); endproperty
   a_rx: assert property (p_rx) else $error("receive decode wrong");
   // Main scenarios reached
   c_ind: cover property (wrSel && regWdata[7:4] == 4'h9);
   c_full: cover property (rdFlag ##1 regRdata[2]);
   c_b2b: cover property (regRd ##1 regRd);
endmodule // srrm_chk
bind srrm_register_map srrm_chk u_chk (.*);
`default_nettype wire

//--- dv/srrm_sense_model.sv
`timescale 1ns/10ps
`default_nettype none
// Sensing engines feeding results and flags
module srrm_sense_model (
   input  wire logic  clk,
   output logic       moveCntFull,
   output logic [15:0] maxNum,
   output logic [15:0] maxDen,
   output logic [15:0] angleIn,
   output logic [95:0] countIn,
   output logic [31:0] ltaIn,
   output logic       resultStb,
   output logic       intervalStb,
   output logic [7:0] intervalIn
);
   // Quiet at time zero
   initial begin
      {moveCntFull, maxNum, maxDen, angleIn, countIn, ltaIn} = '0;
      {resultStb, intervalStb, intervalIn} = '0;
   end
   // One measurement: channel i counts v+i, averages v+0x100+i
   task automatic capture(input logic [15:0] v);
      for (int i = 0; i < 6; i++) countIn[i*16 +: 16] <= v + 16'(i);
      for (int i = 0; i < 2; i++) ltaIn[i*16 +: 16] <= v + 16'h0100 + 16'(i);
      angleIn <= v;
      resultStb <= 1'b1;
      @(posedge clk);
      resultStb <= 1'b0;
   endtask
   // Interval count from the engine
   task automatic loadInt(input logic [7:0] v);
      intervalIn <= v;
      intervalStb <= 1'b1;
      @(posedge clk);
      intervalStb <= 1'b0;
   endtask
   // Counter full level and calibration maxima changes
   task automatic status(input logic f, n, d);
      moveCntFull <= f;
      maxNum <= maxNum + 16'(n);
      maxDen <= maxDen + 16'(d);
      @(posedge clk);
   endtask
endmodule // srrm_sense_model
`default_nettype wire

//--- rtl/srrm_pkg.sv
package srrm_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_RATIO_FLAGS   = 8'h15;
   localparam logic [7:0] ADDR_ANGLE_LO      = 8'h16;
   localparam logic [7:0] ADDR_ANGLE_HI      = 8'h17;
   localparam logic [7:0] ADDR_INTERVAL      = 8'h18;
   localparam logic [7:0] ADDR_COUNT_BASE    = 8'h20;
   localparam logic [7:0] ADDR_LTA_BASE      = 8'h30;
   localparam logic [7:0] ADDR_FE_SEL0       = 8'h40;
   localparam logic [7:0] ADDR_FE_SEL1       = 8'h41;
   localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h60;
   localparam logic [7:0] ADDR_IRQ_MASK      = 8'h61;
   // Field positions of the ratio flags
   localparam int BIT_MOVE_FULL  = 2;
   localparam int BIT_DEN_SET    = 1;
   localparam int BIT_NUM_SET    = 0;
   // Reset values and angle limit
   localparam logic [7:0] RST_INTERVAL = 8'h00;
   localparam logic [7:0] RST_FE_SEL   = 8'h00;
   localparam logic [7:0] RST_IRQ_MASK = 8'h00;
   localparam logic [15:0] ANGLE_MAX   = 16'h0168;
   // Sensor mode codes
   typedef enum logic [3:0] {
      SRRM_MODE_SELF_CAP = 4'b0000,
      SRRM_MODE_MUT_IND  = 4'b1001
   } srrm_mode_t;
   // Front-end select layout
   typedef struct packed {
      logic [3:0] mode;
      logic [1:0] txSel;
      logic [1:0] rxSel;
   } srrm_fesel_t;
   // Electrode drive per channel
   typedef struct packed {
      logic       selfCap;
      logic       mutInd;
      logic [1:0] txEn;
      logic [1:0] rxEn;
   } srrm_fe_t;
endpackage

//--- rtl/srrm_register_map.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - Bit 2 shows movement counter full
// - Bit 1 high when max denominator changes
// - Bit 0 high when max numerator changes
// - Filtered angle read-only, 0 to 360
// - Angle high byte at higher address
// - Interval number readable and writable
// - Per-channel 16-bit count result, read-only
// - Per-channel 16-bit long-term average, read-only
// - Mode code 0000 selects self capacitive
// - Mode code 1001 selects mutual inductive
// - Transmit select 00 disables both transmitters
// - Receive select enables electrodes per code
module srrm_register_map #(
   parameter int NUM_CNT = 6,
   parameter int NUM_LTA = 2
) (
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic [7:0]            regAddr,
   input  wire logic [7:0]            regWdata,
   input  wire logic                  regWr,
   input  wire logic                  regRd,
   output logic      [7:0]            regRdata,
   input  wire logic                  moveCntFull,
   input  wire logic [15:0]           maxNum,
   input  wire logic [15:0]           maxDen,
   input  wire logic [15:0]           angleIn,
   input  wire logic [NUM_CNT*16-1:0] countIn,
   input  wire logic [NUM_LTA*16-1:0] ltaIn,
   input  wire logic                  resultStb,
   input  wire logic                  intervalStb,
   input  wire logic [7:0]            intervalIn,
   output srrm_pkg::srrm_fe_t         frontEnd0,
   output srrm_pkg::srrm_fe_t         frontEnd1,
   output logic      [7:0]            intervalNum,
   output logic                       irq
);
   // Registers
   logic [7:0]            ratioFlags_r;
   logic [15:0]           maxNumPrev_r;
   logic [15:0]           maxDenPrev_r;
   logic [15:0]           angle_r;
   logic [NUM_CNT*16-1:0] count_r;
   logic [NUM_LTA*16-1:0] lta_r;
   logic [7:0]            interval_r;
   logic [7:0]            feSel0_r;
   logic [7:0]            feSel1_r;
   logic [7:0]            irqStat_r;
   logic [7:0]            irqMask_r;
   logic [7:0]            prevFlags_r;
   logic                  hiPending_r;
   logic [7:0]            hiShadow_r;
   logic [7:0]            rdata_r;
   logic                  irq_r;
   srrm_pkg::srrm_fe_t    fe0_r;
   srrm_pkg::srrm_fe_t    fe1_r;

   // Next values and decode
   logic [7:0]            ratioFlags_nxt;
   logic [7:0]            irqStat_nxt;
   logic [7:0]            rdMux;
   logic                  rdLoByte;
   logic [15:0]           rdWord;
   logic                  inCount;
   logic                  inLta;
   logic [7:0]            cntOff;
   logic [7:0]            ltaOff;
   logic [15:0]           angleClamp;
   logic                  holdResults;
   srrm_pkg::srrm_fe_t    fe0_nxt;
   srrm_pkg::srrm_fe_t    fe1_nxt;
   logic                  denChanged;
   logic                  numChanged;
   logic [15:0]           cntWord;
   logic [15:0]           ltaWord;
   logic [7:0]            angleHiByte;
   logic [7:0]            risingFlags;
   logic                  irq_nxt;

   // Access strobes and pairing
   logic                  wrInterval;
   logic                  wrFeSel0;
   logic                  wrFeSel1;
   logic                  wrIrqMask;
   logic                  rdIrqStatus;
   logic                  rdLoCapture;
   logic                  resultLoad;
   logic [7:0]            hiShadow_nxt;
   logic [7:0]            rdata_nxt;

   // Per-channel select decode
   logic [7:0]            feSelArr [2];
   srrm_pkg::srrm_fe_t    feNxtArr [2];

   // Ratio flags from live monitors
   assign denChanged = (maxDen != maxDenPrev_r);
   assign numChanged = (maxNum != maxNumPrev_r);
   always_comb begin
      ratioFlags_nxt = 8'h00;
      ratioFlags_nxt[srrm_pkg::BIT_MOVE_FULL] = moveCntFull;
      ratioFlags_nxt[srrm_pkg::BIT_DEN_SET]   = denChanged;
      ratioFlags_nxt[srrm_pkg::BIT_NUM_SET]   = numChanged;
   end

   // Rising flags become sticky interrupt events
   assign risingFlags = ratioFlags_r & ~prevFlags_r;
   assign rdIrqStatus = regRd && (regAddr == srrm_pkg::ADDR_IRQ_STATUS);
   assign irqStat_nxt = rdIrqStatus ? risingFlags
                                    : (irqStat_r | risingFlags);
   assign irq_nxt     = |(irqStat_nxt & irqMask_r);

   // Angle saturates to the legal span
   assign angleClamp = (angleIn > srrm_pkg::ANGLE_MAX) ? srrm_pkg::ANGLE_MAX
                                                       : angleIn;

   // Results freeze while a high byte is owed to the host
   assign holdResults = hiPending_r;

   // Address classification for 16-bit results
   assign cntOff  = regAddr - srrm_pkg::ADDR_COUNT_BASE;
   assign ltaOff  = regAddr - srrm_pkg::ADDR_LTA_BASE;
   assign inCount = (regAddr >= srrm_pkg::ADDR_COUNT_BASE) &&
                    (cntOff < 8'(2*NUM_CNT));
   assign inLta   = (regAddr >= srrm_pkg::ADDR_LTA_BASE) &&
                    (ltaOff < 8'(2*NUM_LTA));
   assign rdLoByte = inCount ? ~cntOff[0] : ~ltaOff[0];
   assign cntWord  = count_r[16*cntOff[7:1] +: 16];
   assign ltaWord  = lta_r[16*ltaOff[7:1] +: 16];
   assign rdWord   = inCount ? cntWord : ltaWord;
   assign angleHiByte = hiPending_r ? hiShadow_r : angle_r[15:8];

   // Read data multiplexer
   always_comb begin
      rdMux = 8'h00;
      if (inCount || inLta) begin
         if (rdLoByte) begin
            rdMux = rdWord[7:0];
         end else if (hiPending_r) begin
            rdMux = hiShadow_r;
         end else begin
            rdMux = rdWord[15:8];
         end
      end else begin
         case (regAddr)
            srrm_pkg::ADDR_RATIO_FLAGS: rdMux = ratioFlags_r;
            srrm_pkg::ADDR_ANGLE_LO:    rdMux = angle_r[7:0];
            srrm_pkg::ADDR_ANGLE_HI:    rdMux = angleHiByte;
            srrm_pkg::ADDR_INTERVAL:    rdMux = interval_r;
            srrm_pkg::ADDR_FE_SEL0:     rdMux = feSel0_r;
            srrm_pkg::ADDR_FE_SEL1:     rdMux = feSel1_r;
            srrm_pkg::ADDR_IRQ_STATUS:  rdMux = irqStat_r;
            srrm_pkg::ADDR_IRQ_MASK:    rdMux = irqMask_r;
            default:                    rdMux = 8'h00;
         endcase
      end
   end

   // Host write decode
   assign wrInterval = regWr && (regAddr == srrm_pkg::ADDR_INTERVAL);
   assign wrFeSel0   = regWr && (regAddr == srrm_pkg::ADDR_FE_SEL0);
   assign wrFeSel1   = regWr && (regAddr == srrm_pkg::ADDR_FE_SEL1);
   assign wrIrqMask  = regWr && (regAddr == srrm_pkg::ADDR_IRQ_MASK);

   // Low-byte reads owe the matching high byte
   assign rdLoCapture  = regRd && (regAddr == srrm_pkg::ADDR_ANGLE_LO ||
                                   ((inCount || inLta) && rdLoByte));
   assign hiShadow_nxt = (regAddr == srrm_pkg::ADDR_ANGLE_LO) ? angle_r[15:8]
                                                              : rdWord[15:8];
   assign resultLoad   = resultStb && !holdResults;
   assign rdata_nxt    = regRd ? rdMux : 8'h00;

   // One decoder per channel select register
   assign feSelArr[0] = feSel0_r;
   assign feSelArr[1] = feSel1_r;
   for (genvar ch = 0; ch < 2; ch++) begin : g_fe
      srrm_pkg::srrm_fesel_t selFld;
      logic                  modeSelf;
      logic                  modeInd;
      logic [1:0]            txOn;
      logic [1:0]            rxOn;

      // Unknown mode codes leave both mode lines low
      assign selFld   = feSelArr[ch];
      assign modeSelf = (selFld.mode == srrm_pkg::SRRM_MODE_SELF_CAP);
      assign modeInd  = (selFld.mode == srrm_pkg::SRRM_MODE_MUT_IND);
      // Nonzero transmit codes pass through unchanged
      assign txOn     = (selFld.txSel == 2'b00) ? 2'b00 : selFld.txSel;
      assign rxOn     = {selFld.rxSel[1], selFld.rxSel[0]};
      assign feNxtArr[ch] = {modeSelf, modeInd, txOn, rxOn};
   end
   assign fe0_nxt = feNxtArr[0];
   assign fe1_nxt = feNxtArr[1];

   // Ratio flags, one cycle behind the monitors
   // so that a change is seen against a stable history
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ratioFlags_r <= 8'h00;
      end else begin
         ratioFlags_r <= ratioFlags_nxt;
      end
   end

   // Flag history for edge detection
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         prevFlags_r <= 8'h00;
      end else begin
         prevFlags_r <= ratioFlags_r;
      end
   end

   // Numerator history; a nonzero value right after reset
   // shows up as one change
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         maxNumPrev_r <= 16'h0000;
      end else begin
         maxNumPrev_r <= maxNum;
      end
   end

   // Denominator history
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         maxDenPrev_r <= 16'h0000;
      end else begin
         maxDenPrev_r <= maxDen;
      end
   end

   // Angle capture, already clamped
   // to the legal span before it is stored
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         angle_r <= 16'h0000;
      end else if (resultLoad) begin
         angle_r <= angleClamp;
      end
   end

   // Count results capture
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         count_r <= '0;
      end else if (resultLoad) begin
         count_r <= countIn;
      end
   end

   // Long-term average capture
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         lta_r <= '0;
      end else if (resultLoad) begin
         lta_r <= ltaIn;
      end
   end

   // High byte owed; results stay frozen until the next read that is not a low-byte read,
   // so a host that stops after a low byte stalls the results
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         hiPending_r <= 1'b0;
      end else if (rdLoCapture) begin
         hiPending_r <= 1'b1;
      end else if (regRd) begin
         hiPending_r <= 1'b0;
      end
   end

   // High byte snapshot taken with the low byte
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         hiShadow_r <= 8'h00;
      end else if (rdLoCapture) begin
         hiShadow_r <= hiShadow_nxt;
      end
   end

   // Interval number; a host write wins
   // over an engine load in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         interval_r <= srrm_pkg::RST_INTERVAL;
      end else if (wrInterval) begin
         interval_r <= regWdata;
      end else if (intervalStb) begin
         interval_r <= intervalIn;
      end
   end

   // Channel 0 select register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         feSel0_r <= srrm_pkg::RST_FE_SEL;
      end else if (wrFeSel0) begin
         feSel0_r <= regWdata;
      end
   end

   // Channel 1 select register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         feSel1_r <= srrm_pkg::RST_FE_SEL;
      end else if (wrFeSel1) begin
         feSel1_r <= regWdata;
      end
   end

   // Interrupt mask
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irqMask_r <= srrm_pkg::RST_IRQ_MASK;
      end else if (wrIrqMask) begin
         irqMask_r <= regWdata;
      end
   end

   // Sticky status; an edge in the clearing cycle
   // survives the read so no event is lost
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irqStat_r <= 8'h00;
      end else begin
         irqStat_r <= irqStat_nxt;
      end
   end

   // Level interrupt
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   // Read data, zero outside the answer cycle
   // so idle bus values carry no stale bytes
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Channel 0 electrode drive
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         fe0_r <= '0;
      end else begin
         fe0_r <= fe0_nxt;
      end
   end

   // Channel 1 electrode drive
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         fe1_r <= '0;
      end else begin
         fe1_r <= fe1_nxt;
      end
   end

   // Registered outputs
   assign regRdata    = rdata_r;
   assign frontEnd0   = fe0_r;
   assign frontEnd1   = fe1_r;
   assign intervalNum = interval_r;
   assign irq         = irq_r;
endmodule // srrm_register_map
`default_nettype wire
